// >>> test/sbs_line_properties.sv
// Wire-level checks of the shared line between master and slave ends.
module sbs_line_properties (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic m_pulse,
   input wire logic m_pol,
   input wire logic s_pulse,
   input wire logic s_pol,
   input wire logic line_pulse,
   input wire logic line_pol
);
   // ---------------------------------------------------------------
   // Frame tracking
   // ---------------------------------------------------------------
   logic [9:0] qc_q; // Quiet cycles since the last pulse, saturating.
   logic [9:0] fc_q; // Cycles since the current frame's start pulse.
   logic [9:0] fl_q; // Offset of the last pulse seen.
   logic lp_q; // Polarity of the last pulse seen.
   logic par_q; // Running parity of the mid-bit pulses.
   logic mown_q; // High while the current frame is the master's.
   logic st; // A pulse after a full bit time of quiet starts a frame.
   logic [9:0] off;
   assign st = line_pulse && (qc_q >= 10'd60);
   assign off = st ? 10'd0 : fc_q;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   // Reset parks the quiet count high so the first pulse is a start.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         qc_q <= 10'd100;
         fc_q <= 10'd0;
         fl_q <= 10'd0;
         lp_q <= 1'b1;
         par_q <= 1'b1;
         mown_q <= 1'b0;
      end else begin
         qc_q <= line_pulse ? 10'd0 : qc_q + {9'h0, qc_q < 10'd100};
         fc_q <= st ? 10'd1 : fc_q + {9'h0, fc_q < 10'd1000};
         if (line_pulse) begin
            fl_q <= off;
            lp_q <= line_pol;
            mown_q <= st ? m_pulse : mown_q;
            // Stuffing pulses fall between bit centres and carry no data.
            if (off % 10'd60 == 10'd0) begin
               par_q <= (st ? 1'b0 : par_q) ^ line_pol;
            end
         end
      end
   end
   property p_start_neg; st |-> !line_pol; endproperty
   a_start_neg: assert property (p_start_neg) else $error("start not neg");
   property p_alt; line_pulse && !st |-> line_pol != lp_q; endproperty
   a_alt: assert property (p_alt) else $error("equal polarity");
   property p_slot; line_pulse && !st |-> off % 10'd30 == 10'd0; endproperty
   a_slot: assert property (p_slot) else $error("pulse off slot");
   property p_owner; line_pulse && !st |-> m_pulse == mown_q; endproperty
   a_owner: assert property (p_owner) else $error("frames mixed");
   property p_len;
      qc_q == 10'd60 |-> fl_q == (mown_q ? 10'd780 : 10'd360);
   endproperty
   a_len: assert property (p_len) else $error("frame length");
   property p_end_pos; qc_q == 10'd60 |-> lp_q; endproperty
   a_end_pos: assert property (p_end_pos) else $error("end not pos");
   property p_parity; qc_q == 10'd60 |-> par_q; endproperty
   a_parity: assert property (p_parity) else $error("odd parity");
   property p_rsp_gap; st && s_pulse |-> mown_q && qc_q <= 10'd70; endproperty
   a_rsp_gap: assert property (p_rsp_gap) else $error("reply gap");
   c_mst_frame: cover property (qc_q == 10'd60 && mown_q);
   c_slv_frame: cover property (qc_q == 10'd60 && !mown_q);
   c_stuffed: cover property (line_pulse && off % 10'd60 == 10'd30);
endmodule // sbs_line_properties

// >>> test/tb.sv
// Self-checking bench joining the master and slave ends over one line.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Harness
   // ---------------------------------------------------------------
   logic clk, rst, vld, cb, stor, nvm_err, rdy, rsp_vld, rsp_ok, tmo;
   logic [4:0] adr, inf, address;
   logic [3:0] rsp_info, status;
   logic [5:0] err;
   int mismatches, total_checks;
   sbs_line_if line ();
   sbs_master_end i_sbs_master_end (.i_ref_clk(clk), .i_sys_rst(rst),
      .line(line.master), .i_req_vld(vld), .i_req_cb(cb), .i_req_addr(adr),
      .i_req_info(inf), .i_slave_storing(stor), .o_req_rdy(rdy),
      .o_rsp_vld(rsp_vld), .o_rsp_ok(rsp_ok), .o_rsp_info(rsp_info),
      .o_rsp_err(err), .o_rsp_timeout(tmo));
   // The strap is address 5; I/O and identity values are arbitrary.
   sbs_slave_end i_sbs_slave_end (.i_ref_clk(clk), .i_sys_rst(rst),
      .line(line.slave), .i_nv_addr(5'h05), .i_io_cfg(4'ha),
      .i_id_code(4'h6), .i_nvm_read_err(nvm_err), .i_unsync(1'b0),
      .o_status(status), .o_address(address));
   sbs_line_properties i_sbs_line_properties (.i_ref_clk(clk),
      .i_sys_rst(rst), .m_pulse(line.m_pulse), .m_pol(line.m_pol),
      .s_pulse(line.s_pulse), .s_pol(line.s_pol),
      .line_pulse(line.line_pulse), .line_pol(line.line_pol));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Inputs move 5 ns after the edge so they never race the sampling.
   task automatic tick; @(posedge clk); #5; endtask
   task automatic chk(input string n, input logic [4:0] e,
         input logic [4:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   // One request; a refused one must end in the master's timeout.
   task automatic xact(input logic c, input logic [4:0] a,
         input logic [4:0] f, input logic ok, input logic [3:0] d);
      int n;
      n = 0;
      vld = 1'b1; cb = c; adr = a; inf = f;
      while (rdy !== 1'b0 && n < 50) begin tick(); n++; end
      vld = 1'b0;
      while (rsp_vld !== 1'b1 && tmo !== 1'b1 && n < 4000) begin
         tick(); n++;
      end
      chk("outcome", {3'h0, ok, !ok}, {3'h0, rsp_vld, tmo});
      if (ok) begin
         chk("info", {1'b0, d}, {1'b0, rsp_info});
         chk("ok", 5'h01, {4'h0, rsp_ok && err == 6'h00});
      end
      tick();
   endtask
   task automatic t_reads;
      xact(1'b1, 5'h05, 5'h10, 1'b1, 4'ha);
      xact(1'b1, 5'h05, 5'h11, 1'b1, 4'h6);
      xact(1'b1, 5'h05, 5'h12, 1'b1, 4'h0);
   endtask
   task automatic t_status;
      nvm_err = 1'b1; tick(); nvm_err = 1'b0; tick();
      chk("status", 5'h08, {1'b0, status});
      xact(1'b1, 5'h05, 5'h1e, 1'b1, 4'h8);
      xact(1'b1, 5'h05, 5'h1e, 1'b1, 4'h8);
      xact(1'b1, 5'h05, 5'h1f, 1'b1, 4'h8);
      chk("status", 5'h00, {1'b0, status});
   endtask
   task automatic t_delete;
      xact(1'b1, 5'h05, 5'h00, 1'b1, 4'h0);
      chk("address", 5'h00, address);
      chk("status", 5'h01, {1'b0, status});
      xact(1'b1, 5'h05, 5'h10, 1'b0, 4'h0);
      xact(1'b1, 5'h00, 5'h10, 1'b1, 4'ha);
      xact(1'b1, 5'h00, 5'h00, 1'b1, 4'h0);
      chk("status", 5'h01, {1'b0, status});
      xact(1'b1, 5'h00, 5'h1f, 1'b1, 4'h1);
      chk("status", 5'h01, {1'b0, status});
   endtask
   task automatic t_refuse;
      xact(1'b0, 5'h00, 5'h10, 1'b0, 4'h0);
      xact(1'b1, 5'h00, 5'h13, 1'b0, 4'h0);
   endtask
   // A delete held back while the slave stores must never be taken.
   task automatic t_storing;
      stor = 1'b1; vld = 1'b1; cb = 1'b1; adr = 5'h00; inf = 5'h00;
      repeat (20) tick();
      chk("ready", 5'h01, {4'h0, rdy});
      vld = 1'b0; stor = 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   initial begin
      rst = 1'b1; vld = 1'b0; cb = 1'b0; adr = 5'h00; inf = 5'h00;
      stor = 1'b0; nvm_err = 1'b0; mismatches = 0; total_checks = 0;
      repeat (16) @(posedge clk);
      #5 rst = 1'b0;
      tick(); tick();
      chk("address", 5'h05, address);
      t_reads(); t_status(); t_delete(); t_refuse(); t_storing();
      print_verdict();
   end
endmodule // tb

// >>> verilog/sbs_defs.svh
// Timing, frame layout and command code constants for the sensor bus link.
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
// Clock period and bit time, in nanoseconds.
`define SBS_CLK_NS 100
`define SBS_BIT_NS 6000
// Late tolerance on an expected pulse, in nanoseconds.
`define SBS_TOL_LATE_NS 1000
// Derived cycle counts.
`define SBS_BIT_CYC (`SBS_BIT_NS / `SBS_CLK_NS)
`define SBS_HALF_CYC (`SBS_BIT_CYC / 2)
`define SBS_LATE_CYC (`SBS_TOL_LATE_NS / `SBS_CLK_NS)
// Quiet bit times demanded after an end pulse.
`define SBS_SYNC_GAP_BITS 1
`define SBS_UNSYNC_GAP_BITS 3
// Bit times the master waits for a response to start.
`define SBS_RSP_WAIT_BITS 10

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
// Index of the end bit, counted from the start bit as 0.
`define SBS_REQ_END 13
`define SBS_RSP_END 6
// Request fields inside the 14 bit frame, start bit at the top.
`define SBS_REQ_CB 12
`define SBS_REQ_ADDR_LSB 7
`define SBS_REQ_INFO_LSB 2
// Response information field, start bit at bit 6.
`define SBS_RSP_INFO_LSB 2

// ---------------------------------------------------------------
// Commands and status
// ---------------------------------------------------------------
`define SBS_CMD_DEL_ADDR 5'h00
`define SBS_CMD_IO_CFG 5'h10
`define SBS_CMD_ID_CODE 5'h11
`define SBS_CMD_RESERVED 5'h12
`define SBS_CMD_STATUS 5'h1e
`define SBS_CMD_STATUS_CLR 5'h1f
// Information returned for delete-address and the reserved command.
`define SBS_DEL_REPLY 4'h0
`define SBS_RES_REPLY 4'h0
// Status bit positions and reset value.
`define SBS_ST_VOL 0
`define SBS_ST_PAR 1
`define SBS_ST_STOP 2
`define SBS_ST_NVM 3
`define SBS_STATUS_RST 4'h0

`endif

// >>> verilog/sbs_line_if.sv
// Shared two-wire line, modelled as polarity-tagged pulse events.
interface sbs_line_if;

   // Pulse strobes and polarities (1 = positive) from each end.
   logic m_pulse;
   logic m_pol;
   logic s_pulse;
   logic s_pol;
   // What every receiver sees; on a collision the master polarity wins.
   logic line_pulse;
   logic line_pol;

   assign line_pulse = m_pulse | s_pulse;
   assign line_pol = m_pulse ? m_pol : s_pol;

   modport master (output m_pulse, output m_pol,
                   input line_pulse, input line_pol);
   modport slave (output s_pulse, output s_pol,
                  input line_pulse, input line_pol);

endinterface

// >>> verilog/sbs_master_end.sv
// Master end, and the frame receiver that both ends share.
`include "sbs_defs.svh"

// ---------------------------------------------------------------
// Frame receiver
// ---------------------------------------------------------------
module sbs_rx #(parameter int N = 13) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_pulse,
   input wire logic i_pol,
   input wire logic i_unsync,
   output logic o_busy,
   output logic o_done,
   output logic [13:0] o_frame,
   output sbs_pkg::sbs_err_s o_err
);
   sbs_pkg::sbs_rx_e st_q; // Receiver phase.
   logic [11:0] t_q; // Cycles since start pulse, or quiet cycles in tail.
   logic [3:0] k_q; // Index of the next mid-bit pulse expected.
   logic [13:0] sr_q; // Decoded bits after the start bit, which stays a cleared 0 above them.
   logic pol_q; // Polarity of the last pulse seen.
   sbs_pkg::sbs_err_s err_q; // Faults gathered so far.
   logic [11:0] gap; // Last cycle of the quiet window after the end.
   logic fin; // Frame closes this cycle.

   // Nearest half-bit slot of a pulse time, rounding to the middle.
   function automatic logic [11:0] slot_of(input logic [11:0] t);
      slot_of = (t + 12'(`SBS_HALF_CYC / 2)) / 12'(`SBS_HALF_CYC);
   endfunction

   // Last count before pulse k is overdue; the count lags by one.
   function automatic logic [11:0] due_of(input logic [3:0] k);
      due_of = 12'(k) * 12'(`SBS_BIT_CYC) + 12'(`SBS_LATE_CYC - 1);
   endfunction

   // Unsynchronised slaves demand a longer quiet window.
   always_comb begin
      if (i_unsync) begin
         gap = 12'(`SBS_UNSYNC_GAP_BITS * `SBS_BIT_CYC - 1); // see RL21
      end else begin
         gap = 12'(`SBS_SYNC_GAP_BITS * `SBS_BIT_CYC - 1);
      end
   end

   assign fin = (st_q == sbs_pkg::RX_TAIL) && !i_pulse && (t_q == gap);
   assign o_busy = (st_q != sbs_pkg::RX_IDLE);

   // Frame walk: start check, bit decode, window checks, quiet tail.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_q <= sbs_pkg::RX_IDLE;
         t_q <= 12'h000;
         k_q <= 4'h0;
         sr_q <= 14'h0000;
         pol_q <= 1'b1;
         err_q <= '0;
      end else begin
         unique case (st_q)
            sbs_pkg::RX_IDLE: begin
               if (i_pulse) begin
                  t_q <= 12'h000;
                  k_q <= 4'h1;
                  sr_q <= 14'h0000;
                  pol_q <= i_pol;
                  err_q <= '0;
                  // A positive first pulse cannot decode as a 0 bit.
                  err_q.start <= i_pol; // see RL16
                  st_q <= i_pol ? sbs_pkg::RX_TAIL : sbs_pkg::RX_FRAME;
               end
            end
            sbs_pkg::RX_FRAME: begin
               t_q <= t_q + 12'h001;
               if (i_pulse) begin
                  pol_q <= i_pol;
                  if (i_pol == pol_q) begin
                     err_q.alt <= 1'b1; // see RL17
                  end
                  // Only mid-bit pulses carry a bit value.
                  if (slot_of(t_q) == {7'h00, k_q, 1'b0}) begin
                     sr_q <= {sr_q[12:0], i_pol};
                     k_q <= k_q + 4'h1;
                     if (k_q == 4'(N)) begin
                        // The end pulse must rise back to the pause level.
                        err_q.endb <= !i_pol; // see RL20
                        st_q <= sbs_pkg::RX_TAIL;
                        t_q <= 12'h000;
                     end
                  end
               end else if (t_q == due_of(k_q)) begin
                  err_q.noinfo <= 1'b1; // see RL18
                  st_q <= sbs_pkg::RX_TAIL;
                  t_q <= 12'h000;
               end
            end
            sbs_pkg::RX_TAIL: begin
               // Any pulse restarts the quiet window, so a babbling line
               // keeps the frame from being released.
               if (i_pulse) begin
                  err_q.len <= 1'b1; // see RL21
                  t_q <= 12'h000;
               end else if (fin) begin
                  st_q <= sbs_pkg::RX_IDLE;
               end else begin
                  t_q <= t_q + 12'h001;
               end
            end
         endcase
      end
   end

   // Result latch; parity is judged only on a frame that was complete.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_done <= 1'b0;
         o_frame <= 14'h0000;
         o_err <= '0;
      end else begin
         o_done <= fin;
         if (fin) begin
            o_frame <= sr_q;
            o_err <= err_q;
            o_err.parity <= (k_q == 4'(N + 1)) & (^sr_q[N-1:1]); // see RL19
         end
      end
   end
endmodule // sbs_rx

module sbs_master_end (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   sbs_line_if.master line,
   input wire logic i_req_vld,
   input wire logic i_req_cb,
   input wire logic [4:0] i_req_addr,
   input wire logic [4:0] i_req_info,
   input wire logic i_slave_storing,
   output logic o_req_rdy,
   output logic o_rsp_vld,
   output logic o_rsp_ok,
   output logic [3:0] o_rsp_info,
   output sbs_pkg::sbs_err_s o_rsp_err,
   output logic o_rsp_timeout
);
   sbs_pkg::sbs_mst_e st_q; // Sequencing phase.
   logic load_q; // Start the request on the line.
   logic [13:0] frame_q; // Request bits, start bit at bit 13.
   logic [11:0] cnt_q; // Cycles spent waiting for a response.
   logic tx_busy; // Request on the line.
   logic rx_busy; // Response being received.
   logic rx_done; // Response frame closed.
   logic [13:0] rx_frame; // Response bits, start bit at bit 6.
   sbs_pkg::sbs_err_s rx_err; // Response faults.
   logic blocked; // Delete held back while the slave stores.
   logic take; // Request accepted this cycle.

   // Request frame with even parity over control, address and info.
   function automatic logic [13:0] req_frame(input logic cb,
                                             input logic [4:0] a,
                                             input logic [4:0] i);
      req_frame = {1'b0, cb, a, i, ^{cb, a, i}, 1'b1}; // see RL1
   endfunction

   // A delete during an address store would corrupt the stored value.
   assign blocked = i_req_cb && (i_req_info == `SBS_CMD_DEL_ADDR)
                    && i_slave_storing; // see RL7
   assign take = i_req_vld && o_req_rdy && !blocked;

   sbs_tx #(.N(`SBS_REQ_END)) u_tx (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(load_q),
      .i_frame(frame_q),
      .o_busy(tx_busy),
      .o_pulse(line.m_pulse),
      .o_pol(line.m_pol)
   );

   sbs_rx #(.N(`SBS_RSP_END)) u_rx (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_pulse(line.line_pulse & !tx_busy),
      .i_pol(line.line_pol),
      .i_unsync(1'b0),
      .o_busy(rx_busy),
      .o_done(rx_done),
      .o_frame(rx_frame),
      .o_err(rx_err)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // One request in flight; ready returns with the answer or timeout.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_q <= sbs_pkg::M_IDLE;
         o_req_rdy <= 1'b0;
         load_q <= 1'b0;
         frame_q <= 14'h0000;
         cnt_q <= 12'h000;
      end else begin
         load_q <= 1'b0;
         unique case (st_q)
            sbs_pkg::M_IDLE: begin
               o_req_rdy <= !take;
               if (take) begin
                  frame_q <= req_frame(i_req_cb, i_req_addr, i_req_info);
                  load_q <= 1'b1;
                  st_q <= sbs_pkg::M_SEND;
               end
            end
            sbs_pkg::M_SEND: begin
               if (!load_q && !tx_busy) begin
                  st_q <= sbs_pkg::M_WAIT;
                  cnt_q <= 12'h000;
               end
            end
            sbs_pkg::M_WAIT: begin
               cnt_q <= cnt_q + 12'h001;
               // Give up only if no response has started by then.
               if (rx_done || (!rx_busy && cnt_q ==
                   12'(`SBS_RSP_WAIT_BITS * `SBS_BIT_CYC))) begin
                  st_q <= sbs_pkg::M_IDLE;
                  o_req_rdy <= 1'b1;
               end
            end
            default: st_q <= sbs_pkg::M_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Answer outputs
   // ------------------------------------------------------------
   // A faulty response is reported with its faults and not marked ok.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_rsp_vld <= 1'b0;
         o_rsp_ok <= 1'b0;
         o_rsp_info <= 4'h0;
         o_rsp_err <= '0;
         o_rsp_timeout <= 1'b0;
      end else begin
         o_rsp_vld <= 1'b0;
         o_rsp_timeout <= 1'b0;
         if (st_q == sbs_pkg::M_WAIT) begin
            if (rx_done) begin
               o_rsp_vld <= 1'b1;
               o_rsp_ok <= (rx_err == '0); // see RL22
               o_rsp_info <= rx_frame[`SBS_RSP_INFO_LSB +: 4];
               o_rsp_err <= rx_err;
            end else if (!rx_busy && cnt_q ==
                         12'(`SBS_RSP_WAIT_BITS * `SBS_BIT_CYC)) begin
               o_rsp_timeout <= 1'b1;
            end
         end
      end
   end
endmodule // sbs_master_end

// >>> verilog/sbs_pkg.sv
// Shared types of the sensor bus slave and master ends.
package sbs_pkg;

   // Frame check results, one flag per kind of fault.
   typedef struct packed {
      logic start;
      logic alt;
      logic noinfo;
      logic parity;
      logic endb;
      logic len;
   } sbs_err_s;

   // Receiver phases.
   typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_TAIL} sbs_rx_e;

   // Master sequencing phases.
   typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} sbs_mst_e;

endpackage

// >>> verilog/sbs_slave_end.sv
// Slave end: frame sender and command interpreter.
// Notes on behaviour
// RL1 - Request: start 0, control, address, info, parity, end.
// RL2 - Control bit 1 makes info a command.
// RL3 - Command 0x00 deletes the operation address.
// RL4 - Afterwards answer at zero address, held volatile.
// RL5 - Delete leaves the main slave state alone.
// RL6 - Delete at zero address: respond, change nothing.
// RL7 - Master never deletes during non-volatile address store.
// RL8 - Command 0x10 returns I/O configuration.
// RL9 - Command 0x11 returns identification code.
// RL10 - Command 0x1E returns all four status bits.
// RL11 - Reading status leaves status bits unchanged.
// RL12 - Four status bits: volatile, parity, end, memory.
// RL13 - Command 0x1F returns status like 0x1E.
// RL14 - After 0x1F response, clear bits 1-3 only.
// RL15 - Command 0x12 is reserved, gets a standard response.
// RL16 - First pulse after pause must be negative, 0.
// RL17 - Consecutive pulses of equal polarity are an error.
// RL18 - Missing pulse within expected window is an error.
// RL19 - Info plus parity bits must hold even ones.
// RL20 - Pulse at end position must be positive.
// RL21 - Activity right after end pulse is length error.
// RL22 - Any check error discards the whole frame.
// RL23 - Parity and end faults set status; no reply.
`include "sbs_defs.svh"

// ---------------------------------------------------------------
// Frame sender
// ---------------------------------------------------------------
module sbs_tx #(parameter int N = 13) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_load,
   input wire logic [13:0] i_frame,
   output logic o_busy,
   output logic o_pulse,
   output logic o_pol
);
   logic [5:0] t_q; // Cycle within the current bit; 0 is mid-bit.
   logic [3:0] k_q; // Index of the bit being sent.
   logic [13:0] sr_q; // Bits still to send, current one at index N.

   // Each bit gives a mid-bit pulse of its own polarity; equal
   // neighbours need an extra opposite pulse at the boundary.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_busy <= 1'b0;
         o_pulse <= 1'b0;
         o_pol <= 1'b1;
         t_q <= 6'h00;
         k_q <= 4'h0;
         sr_q <= 14'h0000;
      end else begin
         o_pulse <= 1'b0;
         if (!o_busy) begin
            if (i_load) begin
               o_busy <= 1'b1;
               t_q <= 6'h00;
               k_q <= 4'h0;
               sr_q <= i_frame;
            end
         end else begin
            if (t_q == 6'h00) begin
               o_pulse <= 1'b1;
               o_pol <= sr_q[N];
            end else if (t_q == 6'(`SBS_HALF_CYC) && k_q != 4'(N)
                         && sr_q[N-1] == sr_q[N]) begin
               o_pulse <= 1'b1;
               o_pol <= !sr_q[N];
            end
            if (t_q == 6'(`SBS_BIT_CYC - 1)) begin
               t_q <= 6'h00;
               sr_q <= sr_q << 1;
               k_q <= k_q + 4'h1;
               if (k_q == 4'(N)) begin
                  o_busy <= 1'b0;
               end
            end else begin
               t_q <= t_q + 6'h01;
            end
         end
      end
   end
endmodule // sbs_tx

// ---------------------------------------------------------------
// Slave end top
// ---------------------------------------------------------------
module sbs_slave_end (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   sbs_line_if.slave line,
   input wire logic [4:0] i_nv_addr,
   input wire logic [3:0] i_io_cfg,
   input wire logic [3:0] i_id_code,
   input wire logic i_nvm_read_err,
   input wire logic i_unsync,
   output logic [3:0] o_status,
   output logic [4:0] o_address
);
   logic rx_done; // One-cycle strobe: a frame has closed.
   logic [13:0] rx_frame; // Closed frame, start bit at bit 13.
   sbs_pkg::sbs_err_s rx_err; // Faults of the closed frame.
   logic tx_busy; // Response on the line.
   logic tx_load_q; // Start a response.
   logic [13:0] tx_frame_q; // Response bits, start bit at bit 6.
   logic ld_q; // Take the non-volatile address after reset.
   logic clr_pend_q; // Clear faults once the response has gone.
   logic busy_prev_q; // Sender busy one cycle ago.
   logic hit; // Valid command addressed to this slave.
   logic [4:0] code; // Command code of the closed frame.
   logic [3:0] status_d; // Next status bits.

   // Response frame: start 0, info, even parity, end 1.
   function automatic logic [13:0] rsp_frame(input logic [3:0] info);
      rsp_frame = {7'h00, 1'b0, info, ^info, 1'b1};
   endfunction

   // Own transmissions are kept away from the receiver.
   sbs_rx #(.N(`SBS_REQ_END)) u_rx (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_pulse(line.line_pulse & !tx_busy),
      .i_pol(line.line_pol),
      .i_unsync(i_unsync),
      .o_busy(),
      .o_done(rx_done),
      .o_frame(rx_frame),
      .o_err(rx_err)
   );

   sbs_tx #(.N(`SBS_RSP_END)) u_tx (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(tx_load_q),
      .i_frame(tx_frame_q),
      .o_busy(tx_busy),
      .o_pulse(line.s_pulse),
      .o_pol(line.s_pol)
   );

   // Faulty frames never count as a hit, so they get no reply.
   assign code = rx_frame[`SBS_REQ_INFO_LSB +: 5]; // see RL1
   assign hit = rx_done && (rx_err == '0) // see RL22
                && rx_frame[`SBS_REQ_CB] // see RL2
                && (rx_frame[`SBS_REQ_ADDR_LSB +: 5] == o_address);

   // Command decode and response load; unknown codes stay silent.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tx_load_q <= 1'b0;
         tx_frame_q <= 14'h0000;
      end else begin
         tx_load_q <= 1'b0;
         if (hit) begin
            tx_load_q <= 1'b1;
            case (code)
               `SBS_CMD_DEL_ADDR: tx_frame_q <= rsp_frame(`SBS_DEL_REPLY); // see RL6
               `SBS_CMD_IO_CFG: tx_frame_q <= rsp_frame(i_io_cfg); // see RL8
               `SBS_CMD_ID_CODE: tx_frame_q <= rsp_frame(i_id_code); // see RL9
               `SBS_CMD_STATUS: tx_frame_q <= rsp_frame(o_status); // see RL10
               `SBS_CMD_STATUS_CLR: tx_frame_q <= rsp_frame(o_status); // see RL13
               `SBS_CMD_RESERVED: tx_frame_q <= rsp_frame(`SBS_RES_REPLY); // see RL15
               default: tx_load_q <= 1'b0;
            endcase
         end
      end
   end

   // Address: strapped value taken the cycle after reset, dropped to
   // zero by delete, which otherwise changes only the volatile status bit.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ld_q <= 1'b1;
         o_address <= 5'h00;
      end else begin
         ld_q <= 1'b0;
         if (ld_q) begin
            o_address <= i_nv_addr;
         end else if (hit && code == `SBS_CMD_DEL_ADDR
                      && o_address != 5'h00) begin
            o_address <= 5'h00; // see RL3, RL4, RL5
         end
      end
   end

   // Pending clear for read-and-reset, fired when the response ends.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         clr_pend_q <= 1'b0;
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= tx_busy;
         if (hit && code == `SBS_CMD_STATUS_CLR) begin
            clr_pend_q <= 1'b1;
         end else if (busy_prev_q && !tx_busy) begin
            clr_pend_q <= 1'b0;
         end
      end
   end

   // Status: clear first, then sets, so a fault in the clearing cycle
   // survives. Reads alone never touch it.
   always_comb begin
      status_d = o_status; // see RL11
      if (clr_pend_q && busy_prev_q && !tx_busy) begin
         status_d[3:1] = 3'h0; // see RL14
      end
      if (rx_done && rx_err.parity) begin
         status_d[`SBS_ST_PAR] = 1'b1; // see RL23
      end
      if (rx_done && rx_err.endb) begin
         status_d[`SBS_ST_STOP] = 1'b1; // see RL23
      end
      if (i_nvm_read_err) begin
         status_d[`SBS_ST_NVM] = 1'b1; // see RL12
      end
      if (hit && code == `SBS_CMD_DEL_ADDR && o_address != 5'h00) begin
         status_d[`SBS_ST_VOL] = 1'b1; // see RL4
      end
   end

   // Status register.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_status <= `SBS_STATUS_RST;
      end else begin
         o_status <= status_d; // see RL12
      end
   end
endmodule // sbs_slave_end
